// ---- rtl/ocfl_defines.vh ----
// constants for the overcurrent fault limit and response block
`ifndef OCFL_DEFINES_VH
`define OCFL_DEFINES_VH

// ----------------------------------------
// command codes and phase selector
// ----------------------------------------
`define OCFL_CMD_LIMIT 8'h46
`define OCFL_CMD_RESP 8'h47
`define OCFL_PHASE_ALL 8'hFF

// ----------------------------------------
// limit word layout and reset value
// ----------------------------------------
`define OCFL_EXP_HI 15
`define OCFL_EXP_LO 11
`define OCFL_MAN_HI 10
`define OCFL_MAN_LO 0
`define OCFL_EXP_RESET 5'h1E

// ----------------------------------------
// limit ranges in quarter amperes, hardware range in amperes
// ----------------------------------------
`define OCFL_PHASE_MAX_Q 10'h07C
`define OCFL_STACK_MAX_Q 12'h0F8
`define OCFL_HW_MIN_A 5'h04
`define OCFL_HW_MAX_A 5'h1F

// ----------------------------------------
// response byte fields and codes
// ----------------------------------------
`define OCFL_ACT_HI 7
`define OCFL_ACT_LO 6
`define OCFL_RETRY_HI 5
`define OCFL_RETRY_LO 3
`define OCFL_DELAY_HI 2
`define OCFL_DELAY_LO 0
`define OCFL_ACT_IGNORE 2'h0
`define OCFL_ACT_BAD 2'h1
`define OCFL_ACT_DELAY 2'h2
`define OCFL_ACT_NOW 2'h3
`define OCFL_RETRY_NONE 3'h0
`define OCFL_RETRY_FOREVER 3'h7

// ----------------------------------------
// shutdown delays in pwm clock periods
// ----------------------------------------
`define OCFL_DLY_SHORT 4'h3
`define OCFL_DLY_MID 4'h5
`define OCFL_DLY_LONG 4'h9

`endif

// ---- rtl/ocfl_sync_edge.v ----
// two-flop synchroniser for a pin with rising edge detect
module ocfl_sync_edge (
	// clock and reset
	input wire sys_clk,
	input wire reset_n,
	// pin and result
	input wire pin,
	output wire level,
	output wire rise
);

	reg meta;
	reg sync;
	reg prev;

	// first flop feeds only the second one
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
		end else begin
			meta <= pin;
			sync <= meta;
			prev <= sync;
		end
	end

	assign level = sync;
	assign rise = sync & ~prev;

endmodule

// ---- rtl/ocfl_lin_decode.v ----
// linear-format word to quarter amperes, with rounding bits
module ocfl_lin_decode (
	// linear word in
	input wire [15:0] word,
	// quarter-ampere value and flags
	output reg [9:0] q,
	output reg neg,
	output reg over,
	output reg rnd,
	output reg stk
);

	reg signed [5:0] sh;
	reg [5:0] k;
	reg [27:0] wide;
	reg [26:0] frac;

	// shift the mantissa by exponent plus two to reach quarter amperes
	always @* begin
		sh = $signed({word[15], word[15:11]}) + 6'sh02;
		k = 6'h00 - sh;
		wide = 28'h0000000;
		frac = 27'h0000000;
		q = 10'h000;
		over = 1'b0;
		rnd = 1'b0;
		stk = 1'b0;
		neg = word[10];
		if (!sh[5]) begin
			wide = {18'h00000, word[9:0]} << sh[4:0];
			q = wide[9:0];
			over = |wide[27:10];
		end else begin
			frac = {1'b0, word[9:0], 16'h0000} >> k[4:0];
			q = frac[25:16];
			rnd = frac[15];
			stk = |frac[14:0];
		end
	end

endmodule

// ---- rtl/ocfl_core.v ----
// overcurrent fault limit registers and fault response engine
`include "ocfl_defines.vh"

module ocfl_core (
	// clock and reset
	input wire sys_clk,
	input wire reset_n,
	// command port
	input wire cmd_valid,
	input wire cmd_read,
	input wire cmd_word,
	input wire [7:0] cmd_code,
	input wire [15:0] cmd_wdata,
	output reg rsp_valid,
	output reg rsp_ack,
	output reg [15:0] rsp_data,
	// stack setup
	input wire [7:0] phase_select,
	input wire [2:0] num_phases,
	// nonvolatile values
	input wire [10:0] nvm_mantissa,
	input wire [7:0] nvm_response,
	input wire restore_req,
	// power stage control
	input wire op_on,
	input wire startup_ok,
	input wire [15:0] ton_rise_cycles,
	output reg power_enable,
	// pins from outside
	input wire pwm_clk_pin,
	input wire oc_comp_pin,
	// status and alert
	input wire clear_faults,
	output reg current_fault_summary_flag,
	output reg status_word_iout_flag,
	output reg current_fault_flag,
	output reg invalid_data_flag,
	output reg cml_summary_flag,
	output reg alert_n,
	// per-phase hardware limits in amperes
	output reg [19:0] hw_limit_bus
);

	// ----------------------------------------
	// state and storage
	// ----------------------------------------
	localparam ST_IDLE = 3'h0;
	localparam ST_START = 3'h1;
	localparam ST_RUN = 3'h2;
	localparam ST_DELAY = 3'h3;
	localparam ST_HICCUP = 3'h4;
	localparam ST_LATCH = 3'h5;

	reg [15:0] limit_word [0:3];
	reg [7:0] resp;
	reg loaded;
	reg [2:0] state;
	reg [2:0] attempts;
	reg [3:0] dly_cnt;
	reg [15:0] rise_cnt;
	reg [2:0] per_cnt;
	integer i;

	wire [1:0] act = resp[`OCFL_ACT_HI:`OCFL_ACT_LO];
	wire [2:0] retry = resp[`OCFL_RETRY_HI:`OCFL_RETRY_LO];
	wire [2:0] dsel = resp[`OCFL_DELAY_HI:`OCFL_DELAY_LO];

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	wire pwm_rise;
	wire oc_level;
	wire oc_rise;

	ocfl_sync_edge u_pwm (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.pin(pwm_clk_pin),
		.level(),
		.rise(pwm_rise)
	);

	ocfl_sync_edge u_oc (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.pin(oc_comp_pin),
		.level(oc_level),
		.rise(oc_rise)
	);

	// ----------------------------------------
	// write data decode and range check
	// ----------------------------------------
	wire [9:0] wq;
	wire wneg;
	wire wover;
	wire wrnd;
	wire wstk;

	ocfl_lin_decode u_wdec (
		.word(cmd_wdata),
		.q(wq),
		.neg(wneg),
		.over(wover),
		.rnd(wrnd),
		.stk(wstk)
	);

	wire all_sel = (phase_select == `OCFL_PHASE_ALL);
	wire [1:0] idx = phase_select[1:0];
	reg [2:0] n;
	reg [11:0] stack_max;
	reg [9:0] qdiv;
	reg [20:0] div3;

	// phase count, stack ceiling and per-phase share of a written value
	always @* begin
		n = (num_phases == 3'h0 || num_phases > 3'h4) ? 3'h1 : num_phases;
		div3 = {11'h000, wq} * 21'h0002AB;
		case (n)
			3'h2: begin
				stack_max = `OCFL_STACK_MAX_Q << 1;
				qdiv = {1'b0, wq[9:1]};
			end
			3'h3: begin
				stack_max = `OCFL_STACK_MAX_Q * 12'h003;
				qdiv = div3[20:11];
			end
			3'h4: begin
				stack_max = `OCFL_STACK_MAX_Q << 2;
				qdiv = {2'h0, wq[9:2]};
			end
			default: begin
				stack_max = `OCFL_STACK_MAX_Q;
				qdiv = wq;
			end
		endcase
	end

	wire wfrac = wrnd | wstk;
	wire sel_ok = all_sel | ({5'h00, n} > phase_select);
	wire [11:0] wq12 = {2'h0, wq};
	wire stack_ok = (wq12 < stack_max) | ((wq12 == stack_max) & ~wfrac);
	wire phase_ok = (wq < `OCFL_PHASE_MAX_Q) | ((wq == `OCFL_PHASE_MAX_Q) & ~wfrac);
	wire lim_val_ok = ~wneg & ~wover & (all_sel ? stack_ok : phase_ok);
	wire is_lim = (cmd_code == `OCFL_CMD_LIMIT);
	wire is_resp = (cmd_code == `OCFL_CMD_RESP);
	wire wr_lim = cmd_valid & ~cmd_read & is_lim;
	wire wr_resp = cmd_valid & ~cmd_read & is_resp;
	wire lim_ok = cmd_word & sel_ok & lim_val_ok;
	wire resp_ok = ~cmd_word & (cmd_wdata[7:6] != `OCFL_ACT_BAD);
	wire busy_cmd = restore_req | ~loaded;
	wire bad_evt = ~busy_cmd & ((wr_lim & ~lim_ok) | (wr_resp & ~resp_ok));

	// ----------------------------------------
	// per-phase decode: hardware limit and restore rounding
	// ----------------------------------------
	wire [39:0] ph_q;
	wire [63:0] near_bus;
	wire [19:0] hw_next;
	genvar g;

	generate
		for (g = 0; g < 4; g = g + 1) begin : g_ph
			wire rnd;
			wire stk;
			wire [10:0] nq;
			wire [8:0] amps;
			ocfl_lin_decode u_dec (
				.word(limit_word[g]),
				.q(ph_q[g*10 +: 10]),
				.neg(),
				.over(),
				.rnd(rnd),
				.stk(stk)
			);
			// nearest quarter ampere, kept within the stored range
			assign nq = {1'b0, ph_q[g*10 +: 10]} + {10'h000, rnd};
			assign near_bus[g*16 +: 16] = (nq > {1'b0, `OCFL_PHASE_MAX_Q}) ?
				{`OCFL_EXP_RESET, 1'b0, `OCFL_PHASE_MAX_Q} :
				{`OCFL_EXP_RESET, 1'b0, nq[9:0]};
			// whole amperes rounded up, then held to the hardware span
			assign amps = {1'b0, ph_q[g*10+2 +: 8]} +
				{8'h00, (|ph_q[g*10 +: 2]) | rnd | stk};
			assign hw_next[g*5 +: 5] = (amps < {4'h0, `OCFL_HW_MIN_A}) ? `OCFL_HW_MIN_A :
				(amps > {4'h0, `OCFL_HW_MAX_A}) ? `OCFL_HW_MAX_A : amps[4:0];
		end
	endgenerate

	// each phase drives its own comparator threshold, one register for all slices
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			hw_limit_bus <= 20'h00000;
		end else begin
			hw_limit_bus <= hw_next;
		end
	end

	// ----------------------------------------
	// read data: all-phase read scales the master
	// ----------------------------------------
	reg [11:0] all_q;
	reg [15:0] lim_rd;

	always @* begin
		case (n)
			3'h2: all_q = {1'b0, ph_q[9:0], 1'b0};
			3'h3: all_q = {2'h0, ph_q[9:0]} + {1'b0, ph_q[9:0], 1'b0};
			3'h4: all_q = {ph_q[9:0], 2'h0};
			default: all_q = {2'h0, ph_q[9:0]};
		endcase
		if (all_sel) begin
			lim_rd = {`OCFL_EXP_RESET, 1'b0, (|all_q[11:10]) ? 10'h3FF : all_q[9:0]};
		end else begin
			lim_rd = limit_word[idx];
		end
	end

	// ----------------------------------------
	// register file, nonvolatile load and restore
	// ----------------------------------------
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (i = 0; i < 4; i = i + 1) begin
				limit_word[i] <= {`OCFL_EXP_RESET, 11'h000};
			end
			resp <= 8'h00;
			loaded <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_ack <= 1'b0;
			rsp_data <= 16'h0000;
		end else begin
			rsp_valid <= 1'b0;
			if (!loaded) begin
				// first edge after release takes the stored values
				for (i = 0; i < 4; i = i + 1) begin
					limit_word[i] <= {`OCFL_EXP_RESET, nvm_mantissa};
				end
				resp <= nvm_response;
				loaded <= 1'b1;
			end else if (restore_req) begin
				for (i = 0; i < 4; i = i + 1) begin
					limit_word[i] <= near_bus[i*16 +: 16];
				end
				resp <= nvm_response;
			end else if (cmd_valid) begin
				if (cmd_read) begin
					rsp_valid <= 1'b1;
					rsp_ack <= (is_lim & cmd_word & sel_ok) | (is_resp & ~cmd_word);
					rsp_data <= (is_lim & cmd_word & sel_ok) ? lim_rd :
						(is_resp & ~cmd_word) ? {8'h00, resp} : 16'h0000;
				end else if (wr_lim & lim_ok) begin
					if (all_sel) begin
						for (i = 0; i < 4; i = i + 1) begin
							limit_word[i] <= {`OCFL_EXP_RESET, 1'b0, qdiv};
						end
					end else begin
						limit_word[idx] <= cmd_wdata;
					end
				end else if (wr_resp & resp_ok) begin
					resp <= cmd_wdata[7:0];
				end
			end
		end
	end

	// ----------------------------------------
	// response decode: delays and hiccup length
	// ----------------------------------------
	reg [3:0] dly_n;
	reg [2:0] hic_mult;

	always @* begin
		if (dsel < 3'h2) begin
			dly_n = `OCFL_DLY_SHORT;
			hic_mult = 3'h1;
		end else if (dsel < 3'h5) begin
			dly_n = `OCFL_DLY_MID;
			hic_mult = dsel;
		end else begin
			dly_n = `OCFL_DLY_LONG;
			hic_mult = dsel;
		end
	end

	wire live = (state == ST_START) | (state == ST_RUN);
	wire fault_evt = live & ((act == `OCFL_ACT_IGNORE) ? oc_rise : oc_level);
	wire retry_ok = (retry == `OCFL_RETRY_FOREVER) |
		((retry != `OCFL_RETRY_NONE) & (attempts < retry));
	wire [2:0] shut_state = retry_ok ? ST_HICCUP : ST_LATCH;
	wire [15:0] rise_len = (ton_rise_cycles == 16'h0000) ? 16'h0001 : ton_rise_cycles;

	// ----------------------------------------
	// fault response state machine
	// ----------------------------------------
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_IDLE;
			power_enable <= 1'b0;
			attempts <= 3'h0;
			dly_cnt <= 4'h0;
			rise_cnt <= 16'h0000;
			per_cnt <= 3'h0;
		end else if (!op_on || !loaded) begin
			state <= ST_IDLE;
			power_enable <= 1'b0;
			attempts <= 3'h0;
		end else begin
			case (state)
				ST_IDLE: begin
					state <= ST_START;
					power_enable <= 1'b1;
				end
				ST_START, ST_RUN: begin
					if (fault_evt && act != `OCFL_ACT_IGNORE) begin
						if (act == `OCFL_ACT_DELAY) begin
							state <= ST_DELAY;
							dly_cnt <= 4'h0;
						end else begin
							state <= shut_state;
							power_enable <= 1'b0;
							rise_cnt <= 16'h0000;
							per_cnt <= 3'h0;
						end
					end else if (state == ST_START && startup_ok) begin
						state <= ST_RUN;
						attempts <= 3'h0;
					end
				end
				ST_DELAY: begin
					if (pwm_rise) begin
						dly_cnt <= dly_cnt + 4'h1;
						if (dly_cnt + 4'h1 == dly_n) begin
							state <= shut_state;
							power_enable <= 1'b0;
							rise_cnt <= 16'h0000;
							per_cnt <= 3'h0;
						end
					end
				end
				ST_HICCUP: begin
					if (rise_cnt + 16'h0001 >= rise_len) begin
						rise_cnt <= 16'h0000;
						per_cnt <= per_cnt + 3'h1;
						if (per_cnt + 3'h1 >= hic_mult) begin
							state <= ST_START;
							power_enable <= 1'b1;
							if (attempts != 3'h7) begin
								attempts <= attempts + 3'h1;
							end
						end
					end else begin
						rise_cnt <= rise_cnt + 16'h0001;
					end
				end
				ST_LATCH: begin
					power_enable <= 1'b0;
				end
				default: begin
					state <= ST_IDLE;
					power_enable <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// sticky status flags and host alert, set wins over clear
	// ----------------------------------------
	wire next_sum = fault_evt | (current_fault_summary_flag & ~clear_faults);
	wire next_iout = fault_evt | (status_word_iout_flag & ~clear_faults);
	wire next_ocf = fault_evt | (current_fault_flag & ~clear_faults);
	wire next_inv = bad_evt | (invalid_data_flag & ~clear_faults);
	wire next_cml = bad_evt | (cml_summary_flag & ~clear_faults);

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			current_fault_summary_flag <= 1'b0;
			status_word_iout_flag <= 1'b0;
			current_fault_flag <= 1'b0;
			invalid_data_flag <= 1'b0;
			cml_summary_flag <= 1'b0;
			alert_n <= 1'b1;
		end else begin
			current_fault_summary_flag <= next_sum;
			status_word_iout_flag <= next_iout;
			current_fault_flag <= next_ocf;
			invalid_data_flag <= next_inv;
			cml_summary_flag <= next_cml;
			alert_n <= ~(next_sum | next_iout | next_ocf | next_inv | next_cml);
		end
	end

endmodule

// ---- sim/ocfl_core_properties.sv ----
// port-level assertions for the overcurrent fault limit and response block
module ocfl_core_chk (
	// clock and reset
	input logic sys_clk,
	input logic reset_n,
	// command port
	input logic cmd_valid,
	input logic cmd_read,
	input logic cmd_word,
	input logic [7:0] cmd_code,
	input logic [15:0] cmd_wdata,
	input logic restore_req,
	input logic rsp_valid,
	input logic rsp_ack,
	// power and status
	input logic op_on,
	input logic power_enable,
	input logic current_fault_summary_flag,
	input logic status_word_iout_flag,
	input logic current_fault_flag,
	input logic invalid_data_flag,
	input logic alert_n,
	input logic [19:0] hw_limit_bus
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	// a command the block takes: loaded and not beside a restore
	sequence s_take;
		cmd_valid && !restore_req && $past(reset_n);
	endsequence
	sequence s_rd;
		s_take ##0 cmd_read;
	endsequence
	sequence s_wr;
		s_take ##0 !cmd_read;
	endsequence
	a_read_answer: assert property (s_rd |=> rsp_valid)
		else $error("read not answered in one cycle");
	a_answer_cause: assert property (rsp_valid |-> $past(cmd_valid && cmd_read))
		else $error("answer without a read");
	a_resp_width: assert property ((s_rd ##0 cmd_code == 8'h47) |=> rsp_ack == !$past(cmd_word))
		else $error("response read width not honoured");
	a_limit_byte: assert property ((s_wr ##0 cmd_code == 8'h46 && !cmd_word) |=> invalid_data_flag)
		else $error("byte limit write not flagged");
	a_resp_bad: assert property ((s_wr ##0 cmd_code == 8'h47 && !cmd_word
		&& cmd_wdata[7:6] == 2'h1) |=> invalid_data_flag ##0 !alert_n)
		else $error("action code 01 not flagged");
	a_fault_bits: assert property ($rose(current_fault_flag)
		|-> current_fault_summary_flag && status_word_iout_flag)
		else $error("fault bits not set together");
	a_alert_level: assert property ((current_fault_flag || invalid_data_flag) |-> !alert_n)
		else $error("alert not driven while a flag is set");
	a_off_cause: assert property (($fell(power_enable) && $past(op_on)) |-> current_fault_flag)
		else $error("power dropped without a fault");
	a_hw_floor: assert property ($past(reset_n, 2) |-> hw_limit_bus[4:0] >= 5'h04
		&& hw_limit_bus[9:5] >= 5'h04 && hw_limit_bus[14:10] >= 5'h04
		&& hw_limit_bus[19:15] >= 5'h04)
		else $error("hardware limit below 4 A");
endmodule

bind ocfl_core ocfl_core_chk u_chk (.sys_clk, .reset_n, .cmd_valid, .cmd_read, .cmd_word,
	.cmd_code, .cmd_wdata, .restore_req, .rsp_valid, .rsp_ack, .op_on, .power_enable,
	.current_fault_summary_flag, .status_word_iout_flag, .current_fault_flag,
	.invalid_data_flag, .alert_n, .hw_limit_bus);

// ---- sim/ocfl_host_model.sv ----
// host-side model issuing commands to the overcurrent block
module ocfl_host_model (
	// clock
	input logic sys_clk,
	// command strobe and payload
	output logic cmd_valid,
	output logic cmd_read,
	output logic cmd_word,
	output logic [7:0] cmd_code,
	output logic [15:0] cmd_wdata,
	// read answer
	input logic rsp_valid,
	input logic rsp_ack,
	input logic [15:0] rsp_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd_read = 1'b0;
		cmd_word = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
	end
	// one transfer: strobe for one cycle; the read answer stands for one cycle
	// after the taking edge, so it is sampled at the next falling edge
	task xfer(input logic rd, wd, input logic [7:0] c, input logic [15:0] d,
		output logic ack, output logic [15:0] q, output logic ok);
		@(negedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_read <= rd;
		cmd_word <= wd;
		cmd_code <= c;
		cmd_wdata <= d;
		@(negedge sys_clk);
		cmd_valid <= 1'b0;
		cmd_wdata <= ~d; // released bus shows no stale value
		ok = !rd || rsp_valid === 1'b1;
		ack = rsp_ack;
		q = rsp_data;
	endtask
endmodule

// ---- sim/tb_ocfl_core.sv ----
// self-checking bench for the overcurrent fault limit and response block
module tb_ocfl_core;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// signals and instances
	// ----------------------------------------
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic restore_req = 1'b0;
	logic op_on = 1'b0;
	logic startup_ok = 1'b0;
	logic pwm_clk_pin = 1'b0;
	logic oc_comp_pin = 1'b0;
	logic clear_faults = 1'b0;
	logic [7:0] phase_select = 8'h00;
	logic [2:0] num_phases = 3'h1;
	logic [10:0] nvm_mantissa = 11'h028;
	logic [7:0] nvm_response = 8'hC0;
	logic [15:0] ton_rise_cycles = 16'h0014;
	logic cmd_valid, cmd_read, cmd_word, rsp_valid, rsp_ack, power_enable, alert_n;
	logic current_fault_summary_flag, status_word_iout_flag, current_fault_flag;
	logic invalid_data_flag, cml_summary_flag, ack, ok;
	logic [7:0] cmd_code;
	logic [15:0] cmd_wdata, rsp_data, q;
	logic [19:0] hw_limit_bus;
	int err_count = 0;
	int checks = 0;
	int n;
	// system clock, and a pwm pin unrelated in phase
	always #25 sys_clk = ~sys_clk;
	initial begin
		#13;
		forever #200 pwm_clk_pin = ~pwm_clk_pin;
	end
	ocfl_host_model host (.sys_clk, .cmd_valid, .cmd_read, .cmd_word, .cmd_code,
		.cmd_wdata, .rsp_valid, .rsp_ack, .rsp_data);
	ocfl_core uut (.sys_clk, .reset_n, .cmd_valid, .cmd_read, .cmd_word, .cmd_code,
		.cmd_wdata, .rsp_valid, .rsp_ack, .rsp_data, .phase_select, .num_phases,
		.nvm_mantissa, .nvm_response, .restore_req, .op_on, .startup_ok,
		.ton_rise_cycles, .power_enable, .pwm_clk_pin, .oc_comp_pin, .clear_faults,
		.current_fault_summary_flag, .status_word_iout_flag, .current_fault_flag,
		.invalid_data_flag, .cml_summary_flag, .alert_n, .hw_limit_bus);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task chk(input string what, input logic [15:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task cyc(input int k);
		repeat (k) @(negedge sys_clk);
	endtask
	task wr(input logic wd, input logic [7:0] c, input logic [15:0] d);
		host.xfer(1'b0, wd, c, d, ack, q, ok);
	endtask
	task rd(input logic wd, input logic [7:0] c);
		host.xfer(1'b1, wd, c, 16'h0000, ack, q, ok);
		chk("read answered", {15'h0, ok}, 16'h0001);
	endtask
	task clr;
		clear_faults = 1'b1;
		cyc(1);
		clear_faults = 1'b0;
		cyc(1);
	endtask
	// bounded wait for a power level, cycles counted in n
	task wait_pwr(input logic lvl, input int lim);
		n = 0;
		while (power_enable !== lvl) begin
			cyc(1);
			n++;
			if (n > lim) begin
				err_count++;
				$display("CHECK FAILED power_enable expected %b seen %b", lvl, power_enable);
				results;
			end
		end
	endtask
	task pwr_on;
		op_on = 1'b1;
		wait_pwr(1'b1, 5);
		startup_ok = 1'b1;
		cyc(1);
		startup_ok = 1'b0;
	endtask
	task pwr_off;
		op_on = 1'b0;
		cyc(2);
		clr;
	endtask
	function logic [15:0] hw(input int k);
		return {11'h0, hw_limit_bus[5*k +: 5]};
	endfunction
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_limits;
		rd(1'b1, 8'h46);
		chk("reset limit", q, {5'h1E, 11'h028});
		rd(1'b0, 8'h47);
		chk("reset response", q, 16'h00C0);
		chk("hw phase 0", hw(0), 16'h000A);
		num_phases = 3'h2;
		phase_select = 8'h01;
		wr(1'b1, 8'h46, {5'h1E, 11'h035});
		cyc(2);
		rd(1'b1, 8'h46);
		chk("phase 1 limit", q, {5'h1E, 11'h035});
		chk("hw round up", hw(1), 16'h000E);
		chk("hw phase 0 kept", hw(0), 16'h000A);
		wr(1'b1, 8'h46, {5'h1E, 11'h008});
		cyc(2);
		chk("hw floor", hw(1), 16'h0004);
		chk("small accepted", {15'h0, invalid_data_flag}, 16'h0000);
		wr(1'b1, 8'h46, {5'h1E, 11'h07C});
		cyc(2);
		chk("hw top", hw(1), 16'h001F);
		$display("test limits done");
	endtask
	task t_refused;
		wr(1'b1, 8'h46, {5'h1E, 11'h07D});
		cyc(1);
		chk("over limit flag", {14'h0, invalid_data_flag, alert_n}, 16'h0002);
		clr;
		rd(1'b1, 8'h46);
		chk("limit kept", q, {5'h1E, 11'h07C});
		wr(1'b0, 8'h46, 16'h0010);
		cyc(1);
		chk("byte limit flag", {15'h0, invalid_data_flag}, 16'h0001);
		clr;
		wr(1'b1, 8'h47, 16'h0080);
		cyc(1);
		chk("word resp flag", {15'h0, invalid_data_flag}, 16'h0001);
		clr;
		wr(1'b0, 8'h47, 16'h0040);
		cyc(1);
		chk("action 01 flag", {15'h0, cml_summary_flag}, 16'h0001);
		clr;
		rd(1'b0, 8'h47);
		chk("response kept", q, 16'h00C0);
		rd(1'b1, 8'h47);
		chk("word read refused", {15'h0, ack}, 16'h0000);
		$display("test refused done");
	endtask
	task t_phases;
		phase_select = 8'hFF;
		wr(1'b1, 8'h46, {5'h1E, 11'h1F1});
		cyc(1);
		chk("stack over flag", {15'h0, invalid_data_flag}, 16'h0001);
		clr;
		wr(1'b1, 8'h46, {5'h1E, 11'h0A0});
		cyc(2);
		rd(1'b1, 8'h46);
		chk("stack read", q, {5'h1E, 11'h0A0});
		chk("hw split", {hw(0)[7:0], hw(1)[7:0]}, 16'h1414);
		phase_select = 8'h00;
		rd(1'b1, 8'h46);
		chk("master share", q, {5'h1E, 11'h050});
		wr(1'b1, 8'h46, {5'h1C, 11'h0D1});
		cyc(1);
		restore_req = 1'b1;
		cyc(1);
		restore_req = 1'b0;
		cyc(2);
		rd(1'b1, 8'h46);
		chk("restore rounding", q, {5'h1E, 11'h034});
		$display("test phases done");
	endtask
	task t_faults;
		wr(1'b0, 8'h47, 16'h0000);
		pwr_on;
		oc_comp_pin = 1'b1;
		cyc(6);
		chk("ignore keeps power", {15'h0, power_enable}, 16'h0001);
		chk("ignore flags", {15'h0, current_fault_flag}, 16'h0001);
		oc_comp_pin = 1'b0;
		pwr_off;
		wr(1'b0, 8'h47, 16'h00C0);
		pwr_on;
		oc_comp_pin = 1'b1;
		wait_pwr(1'b0, 6);
		chk("fault bits", {13'h0, current_fault_summary_flag, status_word_iout_flag,
			current_fault_flag}, 16'h0007);
		oc_comp_pin = 1'b0;
		cyc(200);
		chk("latched off", {15'h0, power_enable}, 16'h0000);
		pwr_off;
		$display("test faults done");
	endtask
	task t_delays;
		int d[3] = '{0, 2, 5};
		int p[3] = '{3, 5, 9};
		int h[3] = '{1, 2, 5};
		for (int i = 0; i < 3; i++) begin
			wr(1'b0, 8'h47, {8'h00, 5'h17, d[i][2:0]});
			pwr_on;
			@(posedge pwm_clk_pin);
			cyc(4);
			oc_comp_pin = 1'b1;
			wait_pwr(1'b0, 120);
			oc_comp_pin = 1'b0;
			chk("delay", 16'(n >= 8*p[i]-4 && n <= 8*p[i]+4), 16'h0001);
			wait_pwr(1'b1, 200);
			chk("hiccup", 16'(n >= 20*h[i]-2 && n <= 20*h[i]+4), 16'h0001);
			pwr_off;
		end
		$display("test delays done");
	endtask
	task t_retry;
		wr(1'b0, 8'h47, 16'h00C8);
		pwr_on;
		oc_comp_pin = 1'b1;
		wait_pwr(1'b0, 8);
		wait_pwr(1'b1, 30);
		wait_pwr(1'b0, 8);
		cyc(100);
		chk("retries used", {15'h0, power_enable}, 16'h0000);
		oc_comp_pin = 1'b0;
		pwr_off;
		pwr_on;
		oc_comp_pin = 1'b1;
		wait_pwr(1'b0, 8);
		wait_pwr(1'b1, 30);
		oc_comp_pin = 1'b0;
		pwr_off;
		$display("test retry done");
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		cyc(12);
		reset_n = 1'b1;
		cyc(2);
		t_limits;
		t_refused;
		t_phases;
		t_faults;
		t_delays;
		t_retry;
		results;
	end
endmodule
